//--- verilog/sample_hold_gate_sequencer.sv
`timescale 1ns/1ps

// Notes on behaviour
// - four strobes, phase by segment level
// - timing from clock at ten segment rate
// - strobes only in centre of interval
// - track observed segment rate, no fixed speed
// - indicators follow phase and segment sensors
// - dark calibration opens detector input switch
// - electric test substitutes synthetic waveform
module sample_hold_gate_sequencer
    import gate_seq_pkg::*;
#(
    parameter int PERIOD_W = PERIOD_WIDTH,
    parameter int STALL    = STALL_LIMIT
) (
    // clock, reset, enable
    input  wire logic i_clk,
    input  wire logic i_reset,
    input  wire logic i_enable,
    // wheel sensors
    input  wire logic i_phase_sensor,
    input  wire logic i_segment_sensor,
    // diagnostic requests
    input  wire logic i_dark_request,
    input  wire logic i_test_request,
    // sample and hold strobes
    output logic      o_meas_lit_strobe,
    output logic      o_meas_dark_strobe,
    output logic      o_ref_lit_strobe,
    output logic      o_ref_dark_strobe,
    // status indicators
    output logic      o_phase_indicator,
    output logic      o_segment_indicator,
    // detector input switch and test waveform
    output logic      o_detector_switch_closed,
    output logic      o_test_select,
    output logic      o_test_waveform
);

    // whole block state in one register; period fields count system clocks,
    // tick counts tenths of a segment, tick_count steps by ten per system clock
    typedef struct packed {
        logic [1:0]          phase_sync;
        logic [1:0]          seg_sync;
        logic                seg_prev;
        logic [PERIOD_W-1:0] period_count;
        logic [PERIOD_W-1:0] period;
        logic [PERIOD_W-1:0] tick_count;
        logic [3:0]          tick;
        logic                seen_edge;
        logic                locked;
        strobe_type          strobes;
        logic                phase_led;
        logic                seg_led;
        logic                switch_closed;
        logic                test_sel;
        logic [3:0]          test_count;
        logic                test_wave;
    } state_type;

    state_type state;
    state_type next_state;

    // tick position within half segment, centre window check
    function automatic logic in_centre(input logic [3:0] t);
        logic [3:0] half;
        half = (t >= 4'(TICKS_PER_SEGMENT / 2)) ? t - 4'(TICKS_PER_SEGMENT / 2) : t;
        return (half >= 4'(GATE_OPEN_TICK)) && (half <= 4'(GATE_CLOSE_TICK));
    endfunction : in_centre

    // one strobe per phase and segment level
    function automatic strobe_type decode_strobes(
        input logic gate,
        input logic meas_phase,
        input logic seg_high
    );
        strobe_type s;
        s           = '0;
        s.meas_lit  = gate &  meas_phase &  seg_high;
        s.meas_dark = gate &  meas_phase & ~seg_high;
        s.ref_lit   = gate & ~meas_phase &  seg_high;
        s.ref_dark  = gate & ~meas_phase & ~seg_high;
        return s;
    endfunction : decode_strobes

    // input source: test wins over dark, detector otherwise
    function automatic source_type pick_source(
        input logic dark,
        input logic test
    );
        source_type src;
        src = source_detector;
        if (test) begin
            src = source_test;
        end else if (dark) begin
            src = source_open;
        end
        return src;
    endfunction : pick_source

    // reset image: unlocked, strobes low, detector connected,
    // period preset so the tick divider starts from a sane span
    function automatic state_type reset_state();
        state_type r;
        r               = '0;
        r.period        = PERIOD_W'(PERIOD_RESET);
        r.switch_closed = 1'b1;
        return r;
    endfunction : reset_state

    // next state
    always_comb begin
        logic seg_rise;
        logic seg_high;
        logic meas_phase;
        logic gate;
        source_type src;
        next_state = state;
        src        = source_detector;
        seg_rise   = 1'b0;
        seg_high   = 1'b0;
        meas_phase = 1'b0;
        gate       = 1'b0;
        // sensor edges are slow and free running; two flops keep a marginal
        // level from reaching phase and segment decode differently
        // two-stage synchronisers
        next_state.phase_sync = {state.phase_sync[0], i_phase_sensor};
        next_state.seg_sync   = {state.seg_sync[0], i_segment_sensor};
        next_state.seg_prev   = state.seg_sync[1];
        // edge and levels seen only through the synchroniser
        seg_rise   = state.seg_sync[1] & ~state.seg_prev;
        seg_high   = state.seg_sync[1];
        meas_phase = state.phase_sync[1];

        // measure segment period on each rising edge
        // the first edge after reset or a stall closes an unknown span:
        // keep its count but lock only from the next edge onward
        if (seg_rise) begin
            next_state.period_count = '0;
            next_state.period       = state.period_count;
            next_state.seen_edge    = 1'b1;
            next_state.locked       = state.seen_edge;
        end else if (state.period_count >= PERIOD_W'(STALL)) begin
            // no edge for a whole stall span: wheel stopped
            next_state.seen_edge = 1'b0;
            next_state.locked    = 1'b0;
        end else begin
            next_state.period_count = state.period_count + 1'b1;
        end

        // tick 9 holds until the next rise, so a slowing wheel never
        // wraps into an early, misplaced gate
        // tick clock at ten times segment rate, realigned each edge
        if (seg_rise) begin
            next_state.tick_count = '0;
            next_state.tick       = '0;
        end else if (state.tick_count + PERIOD_W'(TICKS_PER_SEGMENT)
                     >= state.period) begin
            next_state.tick_count = '0;
            if (state.tick < 4'(TICKS_PER_SEGMENT - 1)) begin
                next_state.tick = state.tick + 1'b1;
            end
        end else begin
            next_state.tick_count = state.tick_count + PERIOD_W'(TICKS_PER_SEGMENT);
        end

        // window keeps clear of edge ticks 0, 4, 5 and 9
        // gate only in centre of each half segment
        gate = state.locked && in_centre(state.tick);
        // decode phase and segment level, one-hot
        next_state.strobes = decode_strobes(gate, meas_phase, seg_high);

        // same three-clock lag as the strobe decode
        // indicators follow synchronised sensors
        next_state.phase_led = state.phase_sync[1];
        next_state.seg_led   = state.seg_sync[1];

        // dark calibration opens the detector switch
        // test opens it as well and feeds the synthetic wave instead
        src                      = pick_source(i_dark_request, i_test_request);
        next_state.switch_closed = (src == source_detector);
        next_state.test_sel      = (src == source_test);

        // wave restarts low whenever the request drops
        // synthetic square wave locked to tick clock
        if (!i_test_request) begin
            next_state.test_count = '0;
            next_state.test_wave  = 1'b0;
        end else if (state.tick_count == '0) begin
            if (state.test_count >= 4'(TEST_HALF_TICKS - 1)) begin
                next_state.test_count = '0;
                next_state.test_wave  = ~state.test_wave;
            end else begin
                next_state.test_count = state.test_count + 1'b1;
            end
        end
    end

    // state register; enable low holds every field, counters included
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state <= reset_state();
        end else if (i_enable) begin
            state <= next_state;
        end
    end

    // outputs straight from state
    // every output is a state flop, no decode after it
    assign o_meas_lit_strobe        = state.strobes.meas_lit;
    assign o_meas_dark_strobe       = state.strobes.meas_dark;
    assign o_ref_lit_strobe         = state.strobes.ref_lit;
    assign o_ref_dark_strobe        = state.strobes.ref_dark;
    assign o_phase_indicator        = state.phase_led;
    assign o_segment_indicator      = state.seg_led;
    assign o_detector_switch_closed = state.switch_closed;
    assign o_test_select            = state.test_sel;
    assign o_test_waveform          = state.test_wave;

endmodule : sample_hold_gate_sequencer

//--- verilog/gate_seq_pkg.sv
package gate_seq_pkg;

    // strobe vector bit positions
    localparam int STROBE_MEAS_LIT  = 0;
    localparam int STROBE_MEAS_DARK = 1;
    localparam int STROBE_REF_LIT   = 2;
    localparam int STROBE_REF_DARK  = 3;
    localparam int STROBE_COUNT     = 4;

    // multiplied clock: ticks per segment period
    localparam int TICKS_PER_SEGMENT = 10;
    // gate window within each half segment, in ticks (centre only)
    localparam int GATE_OPEN_TICK    = 2;
    localparam int GATE_CLOSE_TICK   = 3;

    // period estimator width, in system clocks
    localparam int PERIOD_WIDTH      = 20;
    // segment period with no edge before declaring the wheel stopped
    localparam int STALL_LIMIT       = 20'h7_a120;

    // test waveform half period, in ticks
    localparam int TEST_HALF_TICKS   = 5;

    // reset values
    localparam logic [PERIOD_WIDTH-1:0] PERIOD_RESET = 20'h0_03e8;

    // input switch source selection
    typedef enum logic [1:0] {
        source_detector,
        source_open,
        source_test
    } source_type;

    // strobe bundle
    typedef struct packed {
        logic ref_dark;
        logic ref_lit;
        logic meas_dark;
        logic meas_lit;
    } strobe_type;

endpackage : gate_seq_pkg

//--- tb/gate_seq_properties.sv
`timescale 1ns/1ps
module gate_seq_properties (
    input wire logic i_clk, i_reset, i_enable, i_phase_sensor, i_segment_sensor,
    input wire logic i_dark_request, i_test_request, o_meas_lit_strobe, o_meas_dark_strobe,
    input wire logic o_ref_lit_strobe, o_ref_dark_strobe, o_phase_indicator,
    input wire logic o_segment_indicator, o_detector_switch_closed, o_test_select,
    input wire logic o_test_waveform
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    // any strobe high
    wire any_s = o_meas_lit_strobe | o_meas_dark_strobe | o_ref_lit_strobe | o_ref_dark_strobe;
    sequence quiet4; !any_s [*4]; endsequence
    sequence sensed(p, g); $past(i_phase_sensor, 3) == p && $past(i_segment_sensor, 3) == g;
    endsequence
    property pick(s, p, g); s |-> sensed(p, g); endproperty
    a_one_strobe: assert property ($onehot0({o_meas_lit_strobe, o_meas_dark_strobe,
        o_ref_lit_strobe, o_ref_dark_strobe})) else $error("two strobes at once");
    a_quiet_reset: assert property ($fell(i_reset) |-> quiet4)
        else $error("strobe right after reset");
    a_meas_lit: assert property (pick(o_meas_lit_strobe, 1'b1, 1'b1))
        else $error("measure lit strobe wrong");
    a_meas_dark: assert property (pick(o_meas_dark_strobe, 1'b1, 1'b0))
        else $error("measure dark strobe wrong");
    a_ref_lit: assert property (pick(o_ref_lit_strobe, 1'b0, 1'b1))
        else $error("reference lit strobe wrong");
    a_ref_dark: assert property (pick(o_ref_dark_strobe, 1'b0, 1'b0))
        else $error("reference dark strobe wrong");
    a_switch_path: assert property (i_enable |=> o_detector_switch_closed ==
        (!$past(i_dark_request) && !$past(i_test_request))) else $error("switch wrong");
    a_test_path: assert property (i_enable |=> o_test_select == $past(i_test_request))
        else $error("test select wrong");
    a_wave_idle: assert property (!o_test_select ##1 !o_test_select |-> !o_test_waveform)
        else $error("wave while test off");
    a_phase_ind: assert property (i_enable [*3] |=>
        o_phase_indicator == $past(i_phase_sensor, 3)) else $error("phase indicator lag");
    a_seg_ind: assert property (i_enable [*3] |=>
        o_segment_indicator == $past(i_segment_sensor, 3)) else $error("segment indicator lag");
endmodule : gate_seq_properties
bind sample_hold_gate_sequencer gate_seq_properties gate_seq_properties_i (.*);

//--- tb/wheel_sensor_model.sv
`timescale 1ns/1ps
module wheel_sensor_model (
    input  wire logic        i_clk,
    input  wire logic        i_run,
    input  wire logic [15:0] i_half,
    output logic             o_phase = 1'b0,
    output logic             o_segment = 1'b0
);
    logic [15:0] cnt = 16'h0000;
    logic [1:0]  halves = 2'h0;
    // segment level flips every half period
    // phase holds for half a turn
    always @(posedge i_clk) begin
        if (i_run) begin
            cnt <= (cnt + 16'h0001 >= i_half) ? 16'h0000 : cnt + 16'h0001;
            if (cnt + 16'h0001 >= i_half) begin
                o_segment <= ~o_segment;
                halves <= halves + 2'h1;
                if (halves == 2'h3) o_phase <= ~o_phase;
            end
        end
    end
endmodule : wheel_sensor_model

//--- tb/tb.sv
`timescale 1ns/1ps
module tb;
    logic i_clk = 1'b0, i_reset = 1'b1, dark = 1'b0, test = 1'b0, run = 1'b0;
    logic [15:0] half = 16'h0064;
    logic [3:0] seen;
    logic lp, ls, en = 1'b1;
    wire phase, seg, ml, md, rl, rd, sw, ts, tw, pi, si;
    int num_errors = 0, check_count = 0, w, n, np;
    sample_hold_gate_sequencer #(.STALL(2000)) sample_hold_gate_sequencer_i (.i_clk, .i_reset,
        .i_enable(en), .i_phase_sensor(phase), .i_segment_sensor(seg), .i_dark_request(dark),
        .i_test_request(test), .o_meas_lit_strobe(ml), .o_meas_dark_strobe(md),
        .o_ref_lit_strobe(rl), .o_ref_dark_strobe(rd), .o_phase_indicator(pi),
        .o_segment_indicator(si), .o_detector_switch_closed(sw), .o_test_select(ts),
        .o_test_waveform(tw));
    wheel_sensor_model wheel_sensor_model_i (.i_clk, .i_run(run), .i_half(half),
        .o_phase(phase), .o_segment(seg));
    initial forever #50 i_clk = ~i_clk;
    task check(input logic s, input logic e);
        check_count++;
        if (s !== e) begin
            num_errors++;
            $display("ERROR %0t value mismatch", $time);
        end
    endtask : check
    // width of the next measure lit strobe
    task width(output int k);
        k = 0;
        for (int i = 0; i < 5000 && ml !== 1'b1; i++) @(negedge i_clk);
        while (ml === 1'b1 && k < 999) begin
            @(negedge i_clk);
            k++;
        end
    endtask : width
    task t_gates;
        seen = 4'h0;
        n = 0;
        np = 0;
        lp = pi;
        ls = si;
        repeat (3000) @(negedge i_clk) begin
            seen |= {rd, rl, md, ml};
            np += int'(pi !== lp);
            n += int'(si !== ls);
            lp = pi;
            ls = si;
        end
        check(seen === 4'hf, 1'b1);
        check(np >= 6, 1'b1);
        check(n >= 24, 1'b1);
        width(w);
        check(w >= 38 && w <= 42, 1'b1);
        $display("gates done");
    endtask : t_gates
    task t_speed;
        @(posedge i_clk) half <= 16'h0096;
        repeat (1500) @(posedge i_clk);
        width(w);
        check(w >= 58 && w <= 62, 1'b1);
        $display("speed done");
    endtask : t_speed
    task t_stall;
        @(posedge i_clk) run <= 1'b0;
        repeat (2400) @(posedge i_clk);
        seen = 4'h0;
        np = 0;
        lp = pi;
        ls = si;
        repeat (500) @(negedge i_clk) begin
            seen |= {rd, rl, md, ml};
            np += int'(pi !== lp || si !== ls);
            lp = pi;
            ls = si;
        end
        check(seen === 4'h0, 1'b1);
        check(np == 0, 1'b1);
        $display("stall done");
    endtask : t_stall
    task t_switch;
        @(posedge i_clk) run <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(posedge i_clk) {test, dark} <= 2'(i);
            @(posedge i_clk);
            @(negedge i_clk);
            check(sw, !i[0] && !i[1]);
            check(ts, i[1]);
            n = 0;
            lp = tw;
            repeat (400) @(negedge i_clk) begin
                n += int'(tw !== lp);
                lp = tw;
            end
            check(n >= 2, i[1]);
        end
        $display("switch done");
    endtask : t_switch
    // enable low must hold a strobe that is already high
    task t_freeze;
        for (int i = 0; i < 5000 && ml !== 1'b1; i++) @(negedge i_clk);
        @(posedge i_clk) begin
            en <= 1'b0;
            run <= 1'b0;
        end
        repeat (60) @(posedge i_clk);
        @(negedge i_clk);
        check(ml, 1'b1);
        @(posedge i_clk) begin
            en <= 1'b1;
            run <= 1'b1;
        end
        $display("freeze done");
    endtask : t_freeze
    // reset in mid-run with dark and test still requested
    task t_reset;
        @(posedge i_clk) i_reset <= 1'b1;
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        check(ml | md | rl | rd, 1'b0);
        check(sw, 1'b1);
        check(ts, 1'b0);
        @(posedge i_clk) i_reset <= 1'b0;
        $display("reset done");
    endtask : t_reset
    task complete_run;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : complete_run
    initial begin
        repeat (2) @(posedge i_clk);
        i_reset <= 1'b0;
        run <= 1'b1;
        t_gates;
        t_speed;
        t_freeze;
        t_stall;
        t_switch;
        t_reset;
        complete_run;
    end
    initial begin
        #3_000_000;
        num_errors++;
        complete_run;
    end
endmodule : tb
